//--- ihp_pkg.sv
package ihp_pkg;

  // ------------------------------------------------------------
  // pin side: register layout of the encoder port
  // ------------------------------------------------------------
  localparam logic [7:0] IHP_OFS_INDEX = 8'h00;
  localparam logic [7:0] IHP_OFS_DATA = 8'h01;
  localparam int IHP_NUM_CTRL = 8;
  localparam logic [7:0] IHP_IDX_LAST_CTRL = 8'h07;
  localparam int IHP_IDX_OVL_BIT = 4;
  localparam logic [2:0] IHP_IDX_STATUS = 3'h2;
  localparam int IHP_STATUS_RO_BIT = 7;
  localparam logic [7:0] IHP_INDEX_RST = 8'h00;
  localparam logic [7:0] IHP_RD_NONE = 8'h00;
  localparam logic [7:0] IHP_BUS_IDLE = 8'hff;
  localparam logic [63:0] IHP_CTRL_RST =
    {8'h00, 8'h07, 8'h25, 8'h00, 8'h00, 8'h02, 8'h04, 8'h79};

  // ------------------------------------------------------------
  // overlay memory geometry: rows 32 apart, 25 columns used
  // ------------------------------------------------------------
  localparam int IHP_COL_W = 5;
  localparam int IHP_ROW_W = 4;
  localparam int IHP_OVL_AW = IHP_ROW_W + IHP_COL_W;
  localparam logic [4:0] IHP_COL_LAST = 5'h18;
  localparam int IHP_DAC_W = 10;

  // ------------------------------------------------------------
  // controller side: avalon register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] IHP_AV_INDEX = 4'h0;
  localparam logic [3:0] IHP_AV_DATA = 4'h4;
  localparam logic [3:0] IHP_AV_STATUS = 4'h8;
  localparam logic [3:0] IHP_AV_STROBE = 4'hc;

  // ------------------------------------------------------------
  // pin cycle timing in ref_clk cycles
  // ------------------------------------------------------------
  localparam logic [7:0] IHP_SETUP_CYC = 8'h04;
  localparam logic [7:0] IHP_STROBE_RST = 8'h0c;
  localparam logic [7:0] IHP_HOLD_CYC = 8'h04;

  typedef enum logic [2:0] {
    IHP_IDLE = 3'b000,
    IHP_SETUP = 3'b001,
    IHP_STROBE = 3'b010,
    IHP_HOLD = 3'b011,
    IHP_ACK = 3'b100
  } ihp_state_e;

endpackage

//--- ihp_host_if.sv
`timescale 1ns/100ps
interface ihp_host_if;
  // ------------------------------------------------------------
  // host port pins
  // ------------------------------------------------------------
  logic address_select_line;
  logic read_not_write;
  logic dev_sel_n;
  logic [7:0] host_d;
  logic host_oe;
  logic [7:0] dev_d;
  logic [7:0] data_lvl;
  logic dev_oe;

  // resolved data bus level, pulled high when nobody drives
  assign data_lvl = host_oe ? host_d : (dev_oe ? dev_d : 8'hff);

  modport dev (
    input address_select_line,
    input read_not_write,
    input dev_sel_n,
    input data_lvl,
    output dev_d,
    output dev_oe
  );

  modport host (
    output address_select_line,
    output read_not_write,
    output dev_sel_n,
    output host_d,
    output host_oe,
    input data_lvl
  );
endinterface

//--- ihp_pin_sync.sv
`timescale 1ns/100ps
module ihp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pins in, filtered level out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] stable
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } ihp_sync_s;

  ihp_sync_s st_r;
  ihp_sync_s st_nxt;

  // ------------------------------------------------------------
  // three stages; a bit changes once stages two and three agree
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.stable = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) |
                    (st_r.stable & (st_r.s2 ^ st_r.s3));
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable = st_r.stable;
endmodule

//--- ihp_dev_port.sv
// Implementation choice: the device end of the host pin port.
`timescale 1ns/100ps
// How it works
// (RQ1) one select, eight data, direction, device select
// (RQ2) select low write loads index register
// (RQ3) select high reaches register chosen by index
// (RQ4) host adds hex 10 to row number
// (RQ5) host writes bursts of 1 to 25 bytes
// (RQ6) burst bytes fill consecutive columns from first
// (RQ7) overlay memory is write only
// (RQ8) index holds until host writes new one
// (RQ9) column pointer wraps after 25th column
// (RQ10) index write clears column pointer
// (RQ11) converters take one sample per clock
// (RQ12) only index bit 4 selects overlay memory
// (RQ13) overlay rows start 32 locations apart
// (RQ14) device select qualifies; direction picks driver
module ihp_dev_port
  import ihp_pkg::*;
#(
  parameter logic [63:0] CTRL_RST = IHP_CTRL_RST
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host port pins
  ihp_host_if.dev pins,
  // control register contents and status
  output logic [63:0] ctrl_regs,
  input wire logic vblank_flag,
  // overlay memory write port
  output logic ovl_we,
  output logic [IHP_OVL_AW-1:0] ovl_addr,
  output logic [7:0] ovl_data,
  // converter samples
  input wire logic [3*IHP_DAC_W-1:0] dac_in,
  output logic [3*IHP_DAC_W-1:0] dac_out
);

  typedef struct packed {
    logic sel_act;
    logic [7:0] index;
    logic [IHP_COL_W-1:0] col;
    logic [63:0] regs;
    logic [7:0] rd_data;
    logic rd_oe;
    logic ovl_we;
    logic [IHP_OVL_AW-1:0] ovl_addr;
    logic [7:0] ovl_data;
    logic [3*IHP_DAC_W-1:0] dac;
  } ihp_dev_s;

  ihp_dev_s st_r;
  ihp_dev_s st_nxt;

  logic [10:0] pin_stable;
  logic sel_n_s;
  logic a0_s;
  logic rnw_s;
  logic [7:0] d_s;
  logic acc_start;
  logic acc_end;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  ihp_pin_sync #(
    .W(11),
    .RST_VAL(11'h7ff)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in({pins.dev_sel_n, pins.address_select_line,
             pins.read_not_write, pins.data_lvl}),
    .stable(pin_stable)
  );

  assign sel_n_s = pin_stable[10];
  assign a0_s = pin_stable[9];
  assign rnw_s = pin_stable[8];
  assign d_s = pin_stable[7:0];

  // access begins on select assert, ends on release
  assign acc_start = !st_r.sel_act && !sel_n_s; // RQ14
  assign acc_end = st_r.sel_act && sel_n_s;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // index points at overlay memory; one bit decides
  function automatic logic is_ovl(
    input logic [7:0] idx
  );
    return idx[IHP_IDX_OVL_BIT]; // RQ12
  endfunction

  // index names one of the control registers
  function automatic logic is_ctrl(
    input logic [7:0] idx
  );
    return idx <= IHP_IDX_LAST_CTRL;
  endfunction

  // index names the register holding the read-only flag
  function automatic logic is_status(
    input logic [7:0] idx
  );
    return idx[2:0] == IHP_IDX_STATUS;
  endfunction

  // control register write; the status msb keeps its old value
  function automatic logic [63:0] reg_write(
    input logic [63:0] regs,
    input logic [7:0] idx,
    input logic [7:0] d
  );
    logic [63:0] r;
    logic [7:0] b;
    r = regs;
    b = d;
    if (is_status(idx)) begin
      b[IHP_STATUS_RO_BIT] = regs[idx[2:0]*8 + IHP_STATUS_RO_BIT];
    end
    r[idx[2:0]*8 +: 8] = b;
    return r;
  endfunction

  // read value of the data register for a given index
  function automatic logic [7:0] data_read(
    input logic [7:0] idx,
    input logic [63:0] regs,
    input logic vb
  );
    logic [7:0] v;
    v = IHP_RD_NONE;
    if (is_ovl(idx)) begin
      v = IHP_RD_NONE; // RQ7
    end else if (is_ctrl(idx)) begin
      v = regs[idx[2:0]*8 +: 8];
      if (is_status(idx)) begin
        v[IHP_STATUS_RO_BIT] = vb;
      end
    end
    return v;
  endfunction

  // next column, wrapping after the last one
  function automatic logic [IHP_COL_W-1:0] col_step(
    input logic [IHP_COL_W-1:0] c
  );
    logic [IHP_COL_W-1:0] n;
    n = (c == IHP_COL_LAST) ? '0 : c + 1'b1; // RQ9
    return n;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovl_we = 1'b0;
    st_nxt.dac = dac_in; // RQ11
    if (acc_start) begin
      st_nxt.sel_act = 1'b1;
      if (rnw_s) begin
        // device drives the bus for a read
        st_nxt.rd_oe = 1'b1; // RQ14
        if (a0_s) begin
          st_nxt.rd_data = data_read(st_r.index, st_r.regs,
                                     vblank_flag); // RQ3
        end else begin
          st_nxt.rd_data = st_r.index;
        end
      end else if (!a0_s) begin
        st_nxt.index = d_s; // RQ2
        st_nxt.col = '0; // RQ10
      end else if (is_ovl(st_r.index)) begin
        // overlay burst byte, row from low index bits
        st_nxt.ovl_we = 1'b1; // RQ12
        st_nxt.ovl_addr = {st_r.index[IHP_ROW_W-1:0], st_r.col}; // RQ13
        st_nxt.ovl_data = d_s; // RQ6
        st_nxt.col = col_step(st_r.col); // RQ6
      end else if (is_ctrl(st_r.index)) begin
        // control register write; status msb stays read only
        st_nxt.regs = reg_write(st_r.regs, st_r.index, d_s); // RQ3
      end
    end
    if (acc_end) begin
      st_nxt.sel_act = 1'b0;
      st_nxt.rd_oe = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register; index only changes on index writes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{sel_act: 1'b0, index: IHP_INDEX_RST, col: '0,
                regs: CTRL_RST, rd_data: IHP_RD_NONE, rd_oe: 1'b0,
                ovl_we: 1'b0, ovl_addr: '0, ovl_data: 8'h00,
                dac: '0};
    end else begin
      st_r <= st_nxt; // RQ8
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pins.dev_d = st_r.rd_data;
  assign pins.dev_oe = st_r.rd_oe;
  assign ctrl_regs = st_r.regs;
  assign ovl_we = st_r.ovl_we;
  assign ovl_addr = st_r.ovl_addr;
  assign ovl_data = st_r.ovl_data;
  assign dac_out = st_r.dac;
endmodule

//--- ihp_host_ctrl.sv
`timescale 1ns/100ps
module ihp_host_ctrl
  import ihp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // host port pins
  ihp_host_if.host pins
);

  typedef struct packed {
    ihp_state_e state;
    logic [7:0] cnt;
    logic [7:0] strobe_len;
    logic [IHP_COL_W-1:0] col;
    logic ovl_sel;
    logic a0;
    logic rnw;
    logic sel_n;
    logic [7:0] wd;
    logic oe;
    logic [31:0] rdata;
  } ihp_host_s;

  ihp_host_s st_r;
  ihp_host_s st_nxt;
  logic [7:0] d_s;
  logic pin_req;

  // ------------------------------------------------------------
  // read data synchroniser
  // ------------------------------------------------------------
  ihp_pin_sync #(
    .W(8),
    .RST_VAL(IHP_BUS_IDLE)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(pins.data_lvl),
    .stable(d_s)
  );

  assign pin_req = (address == IHP_AV_INDEX) || (address == IHP_AV_DATA);

  // ------------------------------------------------------------
  // pin cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      IHP_IDLE: begin
        if ((read || write) && pin_req) begin
          st_nxt.a0 = (address == IHP_AV_DATA); // RQ2
          st_nxt.rnw = read;
          st_nxt.wd = writedata[7:0];
          st_nxt.oe = write; // RQ14
          st_nxt.cnt = IHP_SETUP_CYC;
          st_nxt.state = IHP_SETUP;
        end else if (read || write) begin
          st_nxt.rdata = 32'h0000_0000;
          if (read && address == IHP_AV_STATUS) begin
            st_nxt.rdata = {26'h0, st_r.ovl_sel, st_r.col};
          end else if (read && address == IHP_AV_STROBE) begin
            st_nxt.rdata = {24'h0, st_r.strobe_len};
          end else if (write && address == IHP_AV_STROBE) begin
            st_nxt.strobe_len = writedata[7:0];
          end
          st_nxt.state = IHP_ACK;
        end
      end
      IHP_SETUP: begin
        st_nxt.cnt = st_r.cnt - 8'h01;
        if (st_r.cnt == 8'h01) begin
          st_nxt.sel_n = 1'b0;
          st_nxt.cnt = st_r.strobe_len;
          st_nxt.state = IHP_STROBE;
        end
      end
      IHP_STROBE: begin
        st_nxt.cnt = st_r.cnt - 8'h01;
        if (st_r.cnt <= 8'h01) begin
          st_nxt.sel_n = 1'b1;
          st_nxt.rdata = {24'h0, d_s};
          st_nxt.cnt = IHP_HOLD_CYC;
          st_nxt.state = IHP_HOLD;
          // track the device column pointer
          if (!st_r.rnw && !st_r.a0) begin
            st_nxt.ovl_sel = st_r.wd[IHP_IDX_OVL_BIT]; // RQ4
            st_nxt.col = '0;
          end else if (!st_r.rnw && st_r.ovl_sel) begin
            st_nxt.col = (st_r.col == IHP_COL_LAST) ? '0 :
                         st_r.col + 1'b1; // RQ5
          end
        end
      end
      IHP_HOLD: begin
        st_nxt.cnt = st_r.cnt - 8'h01;
        if (st_r.cnt == 8'h01) begin
          st_nxt.oe = 1'b0;
          st_nxt.state = IHP_ACK;
        end
      end
      IHP_ACK: begin
        st_nxt.state = IHP_IDLE;
      end
      default: begin
        st_nxt.state = IHP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{state: IHP_IDLE, cnt: 8'h00, strobe_len: IHP_STROBE_RST,
                col: '0, ovl_sel: 1'b0, a0: 1'b0, rnw: 1'b1,
                sel_n: 1'b1, wd: 8'h00, oe: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign waitrequest = (st_r.state != IHP_ACK);
  assign readdata = st_r.rdata;
  assign pins.address_select_line = st_r.a0; // RQ1
  assign pins.read_not_write = st_r.rnw;
  assign pins.dev_sel_n = st_r.sel_n; // RQ14
  assign pins.host_d = st_r.wd;
  assign pins.host_oe = st_r.oe;
endmodule

//--- ihp_properties.sv
`timescale 1ns/100ps
module ihp_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host port pins
  input wire logic address_select_line,
  input wire logic read_not_write,
  input wire logic dev_sel_n,
  input wire logic [7:0] host_d,
  input wire logic host_oe,
  input wire logic [7:0] dev_d,
  input wire logic dev_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // pin cycle steps
  // ------------------------------------------------------------
  sequence s_sel_fall;
    $fell(dev_sel_n);
  endsequence
  sequence s_sel_held;
    !dev_sel_n [*8];
  endsequence
  // ------------------------------------------------------------
  // pin rules
  // ------------------------------------------------------------
  AST_NO_FIGHT: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the data bus");
  AST_HOST_DRIVES_WR: assert property (host_oe |-> !read_not_write)
    else $error("host drives data on a read");
  AST_DEV_DRIVES_RD: assert property (
    $rose(dev_oe) |-> read_not_write && !dev_sel_n)
    else $error("device drives data outside a read");
  AST_SETUP: assert property (
    s_sel_fall |-> $past(address_select_line, 4) == address_select_line &&
      $past(read_not_write, 4) == read_not_write)
    else $error("select changed too close to strobe");
  AST_SEL_LEN: assert property (s_sel_fall |-> s_sel_held)
    else $error("strobe shorter than eight cycles");
  AST_CTRL_HOLD: assert property (
    !dev_sel_n |-> $stable(address_select_line) && $stable(read_not_write))
    else $error("control lines moved during strobe");
  AST_DATA_HOLD: assert property (
    !dev_sel_n && host_oe |-> $stable(host_d))
    else $error("write data moved during strobe");
  AST_READ_ANSWER: assert property (
    s_sel_fall ##0 read_not_write |-> ##[2:8] dev_oe)
    else $error("device did not answer a read");
  AST_OE_RELEASE: assert property (
    $rose(dev_sel_n) |-> ##[1:8] !dev_oe)
    else $error("device kept driving after release");
  AST_DEV_D_STEADY: assert property (
    dev_oe && $past(dev_oe) |-> $stable(dev_d))
    else $error("read data moved while driven");
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
  import ihp_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic vblank_flag = 1'b0;
  logic [29:0] dac_in = 30'h0;
  logic [29:0] dac_out;
  logic [29:0] dac_prev = 30'h0;
  logic [63:0] ctrl_regs;
  logic ovl_we;
  logic [8:0] ovl_addr;
  logic [7:0] ovl_data;
  logic [31:0] rd;
  logic [7:0] exp_ctrl [8];
  logic [16:0] seen_q [$];
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam int LIMIT = 20000;

  always #12.5 ref_clk = ~ref_clk;

  ihp_host_if hif ();
  ihp_host_ctrl u_ihp_host_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pins(hif));
  ihp_dev_port u_ihp_dev_port (.ref_clk(ref_clk), .reset_n(reset_n),
    .pins(hif), .ctrl_regs(ctrl_regs), .vblank_flag(vblank_flag),
    .ovl_we(ovl_we), .ovl_addr(ovl_addr), .ovl_data(ovl_data),
    .dac_in(dac_in), .dac_out(dac_out));
  ihp_properties u_ihp_properties (.ref_clk(ref_clk), .reset_n(reset_n),
    .address_select_line(hif.address_select_line),
    .read_not_write(hif.read_not_write), .dev_sel_n(hif.dev_sel_n),
    .host_d(hif.host_d), .host_oe(hif.host_oe), .dev_d(hif.dev_d),
    .dev_oe(hif.dev_oe));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task av(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // expected data read; vblank shows in bit 7 of index 2
  function logic [7:0] exp_rd(input int k);
    exp_rd = (k == 2) ? {vblank_flag, exp_ctrl[2][6:0]} : exp_ctrl[k];
  endfunction

  task chk_ctrl();
    for (int k = 0; k < 8; k++) begin
      chk(ctrl_regs[8*k+:8] & (k == 2 ? 8'h7f : 8'hff),
        exp_ctrl[k] & (k == 2 ? 8'h7f : 8'hff));
    end
  endtask

  // select a row, write n bytes, compare captured memory writes
  task automatic burst(input logic [7:0] idx, input int n);
    logic [7:0] d [$];
    av(IHP_AV_INDEX, 1'b1, idx);
    seen_q.delete();
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($urandom));
      av(IHP_AV_DATA, 1'b1, d[i]);
    end
    chk(seen_q.size(), n);
    for (int i = 0; i < n && i < seen_q.size(); i++) begin
      chk(seen_q[i], {idx[3:0], 5'(i % 25), d[i]});
    end
  endtask

  // ------------------------------------------------------------
  // free-running stimulus, monitor and watchdog
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    dac_in <= 30'($urandom);
    dac_prev <= dac_in;
    if (cyc > 5) chk(dac_out, dac_prev);
    if (ovl_we === 1'b1) seen_q.push_back({ovl_addr, ovl_data});
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    void'($urandom(72647));
    for (int k = 0; k < 8; k++) exp_ctrl[k] = IHP_CTRL_RST[8*k+:8];
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk_ctrl();
    av(IHP_AV_STROBE, 1'b0, 8'h00);
    chk(rd, 32'h0c);
    av(IHP_AV_STROBE, 1'b1, 8'h0d);
    av(IHP_AV_STROBE, 1'b0, 8'h00);
    chk(rd, 32'h0d);
    av(4'h2, 1'b1, 8'h5a);
    av(4'h2, 1'b0, 8'h00);
    chk(rd, 32'h0);
    for (int k = 0; k < 8; k++) begin
      vblank_flag <= 1'($urandom);
      d = 8'($urandom);
      av(IHP_AV_INDEX, 1'b1, 8'(k));
      av(IHP_AV_DATA, 1'b1, d);
      exp_ctrl[k] = d;
      av(IHP_AV_DATA, 1'b0, 8'h00);
      chk(rd, exp_rd(k));
      av(IHP_AV_INDEX, 1'b0, 8'h00);
      chk(rd, k);
    end
    chk_ctrl();
    chk(seen_q.size(), 0);
    d = 8'h08 + 8'($urandom % 8);
    av(IHP_AV_INDEX, 1'b1, d);
    av(IHP_AV_DATA, 1'b1, 8'($urandom));
    av(IHP_AV_DATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    chk_ctrl();
    burst(8'h10, 27);
    av(IHP_AV_STATUS, 1'b0, 8'h00);
    chk(rd[5:0], 6'h22);
    av(IHP_AV_DATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    av(IHP_AV_INDEX, 1'b0, 8'h00);
    chk(rd, 32'h10);
    burst(8'h39, 3);
    burst(8'h10 + 8'($urandom % 10), 1 + ($urandom % 25));
    burst(8'h30, 25);
    av(IHP_AV_STATUS, 1'b0, 8'h00);
    chk(rd[5:0], 6'h20);
    conclude();
  end
endmodule
